//--- logic/tcp_pkg.sv
// Constants, field layouts and types shared by the timer block.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
package tcp_pkg;

    // Register byte offsets
    localparam logic [11:0] CFG_OFF   = 12'h000;
    localparam logic [11:0] MODE_OFF  = 12'h004;
    localparam logic [11:0] CTL_OFF   = 12'h00C;
    localparam logic [11:0] IMR_OFF   = 12'h018;
    localparam logic [11:0] RIS_OFF   = 12'h01C;
    localparam logic [11:0] MIS_OFF   = 12'h020;
    localparam logic [11:0] ICR_OFF   = 12'h024;
    localparam logic [11:0] ILR_OFF   = 12'h028;
    localparam logic [11:0] MATCH_OFF = 12'h030;
    localparam logic [11:0] PRE_OFF   = 12'h038;
    localparam logic [11:0] VAL_OFF   = 12'h048;

    // Global configuration values
    localparam logic [2:0] CFG_32  = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam logic [2:0] CFG_16  = 3'h4;

    // Timer mode field values
    localparam logic [1:0] MR_ONESHOT  = 2'h1;
    localparam logic [1:0] MR_PERIODIC = 2'h2;
    localparam logic [1:0] MR_CAPTURE  = 2'h3;

    // Edge select encodings
    localparam logic [1:0] EV_RISE = 2'h0;
    localparam logic [1:0] EV_FALL = 2'h1;
    localparam logic [1:0] EV_BOTH = 2'h3;

    // Status bit positions
    localparam int IRQ_TO  = 0;
    localparam int IRQ_CM  = 1;
    localparam int IRQ_CE  = 2;
    localparam int IRQ_RTC = 3;

    // Values after reset, RTC start value and bus response codes
    localparam logic [31:0] ILR_RST   = 32'hFFFF_FFFF;
    localparam logic [31:0] MATCH_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] CNT_RST   = 32'hFFFF_FFFF;
    localparam logic [31:0] RTC_START = 32'h0000_0001;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;

    // Mode register layout, bit 3 down to bit 0
    typedef struct packed {
        logic       alternate_mode_select;
        logic       capture_mode_bit;
        logic [1:0] timer_mode_field;
    } tcp_mode_s;

    // Control register layout, bit 6 down to bit 0
    typedef struct packed {
        logic       output_invert_bit;
        logic       rsv5;
        logic       rtc_debug_run_bit;
        logic [1:0] edge_select_field;
        logic       rsv1;
        logic       timer_run_bit;
    } tcp_ctl_s;

    typedef enum logic [2:0] {
        OP_IDLE, OP_32, OP_RTC, OP_16, OP_ECNT, OP_ETIME, OP_PWM
    } tcp_op_e;

endpackage

//--- logic/tcp_timer.sv
// General-purpose timer: 32-bit, RTC, 16-bit, edge count, edge time, PWM.
// Assumes an AXI4-Lite master on clock_i and an asynchronous capture pin.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tcp_timer #(
    parameter int RTC_DIV = 32768
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [11:0] awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [11:0] araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    input  wire logic        ccp_i,
    output logic             ccp_o,
    output logic             ccp_oe_o
);

    if (RTC_DIV < 2 || RTC_DIV > 65536) begin : g_chk
        $error("RTC_DIV out of range");
    end

    logic [2:0]          cfg_reg;
    tcp_pkg::tcp_mode_s  mode_reg;
    tcp_pkg::tcp_ctl_s   ctl_reg;
    logic [3:0]          imr_reg;
    logic [3:0]          ris_reg;
    logic [31:0]         ilr_reg;
    logic [31:0]         match_reg;
    logic [7:0]          pre_reg;
    logic [7:0]          pdiv_reg;
    logic [31:0]         cnt_reg;
    logic [31:0]         cap_reg;
    logic                ilr_wr_reg;
    logic                lvl_reg;
    logic [16:0]         rdiv_reg;
    logic                s1_reg;
    logic                s2_reg;
    logic                s3_reg;
    logic                aw_full_reg;
    logic                w_full_reg;
    logic [11:0]         waddr_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
        end
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = a == tcp_pkg::CFG_OFF || a == tcp_pkg::MODE_OFF || a == tcp_pkg::CTL_OFF
              || a == tcp_pkg::IMR_OFF || a == tcp_pkg::RIS_OFF || a == tcp_pkg::MIS_OFF
              || a == tcp_pkg::ICR_OFF || a == tcp_pkg::ILR_OFF || a == tcp_pkg::MATCH_OFF
              || a == tcp_pkg::PRE_OFF || a == tcp_pkg::VAL_OFF;
    endfunction

    function automatic logic [31:0] w16(input logic h, input logic [31:0] x);
        w16 = h ? {16'h0000, x[15:0]} : x;
    endfunction

    function automatic tcp_pkg::tcp_op_e op_of(input logic [2:0] c, input tcp_pkg::tcp_mode_s m);
        op_of = tcp_pkg::OP_IDLE;
        if (c == tcp_pkg::CFG_32) begin
            if (m.timer_mode_field == tcp_pkg::MR_ONESHOT
                || m.timer_mode_field == tcp_pkg::MR_PERIODIC) begin
                op_of = tcp_pkg::OP_32;
            end
        end else if (c == tcp_pkg::CFG_RTC) begin
            op_of = tcp_pkg::OP_RTC;
        end else if (c == tcp_pkg::CFG_16) begin
            if (m.alternate_mode_select) begin
                if (!m.capture_mode_bit && m.timer_mode_field == tcp_pkg::MR_PERIODIC) begin
                    op_of = tcp_pkg::OP_PWM;
                end
            end else if (m.timer_mode_field == tcp_pkg::MR_CAPTURE) begin
                op_of = m.capture_mode_bit ? tcp_pkg::OP_ETIME : tcp_pkg::OP_ECNT;
            end else if (m.timer_mode_field != 2'h0) begin
                op_of = tcp_pkg::OP_16;
            end
        end
    endfunction

    // Decode and event terms
    tcp_pkg::tcp_op_e op;
    logic             run;
    logic             h16;
    logic             we;
    logic [31:0]      ilr_v;
    logic [31:0]      match_v;
    logic [31:0]      dec;
    logic             zero;
    logic             pre_on;
    logic             tick;
    logic             rise;
    logic             fall;
    logic             sel_edge;
    logic             rtc_tick;
    logic             to_evt;
    logic             cm_evt;
    logic             ce_evt;
    logic             rtc_evt;
    logic [3:0]       clr;

    assign op       = op_of(cfg_reg, mode_reg);
    assign run      = ctl_reg.timer_run_bit;
    assign h16      = cfg_reg == tcp_pkg::CFG_16;
    assign we       = aw_full_reg && w_full_reg && !bvalid_o;
    assign ilr_v    = w16(h16, ilr_reg);
    assign match_v  = w16(h16, match_reg);
    assign dec      = cnt_reg - 32'h0000_0001;
    assign zero     = w16(h16, cnt_reg) == 32'h0000_0000;
    assign pre_on   = op == tcp_pkg::OP_16 || op == tcp_pkg::OP_PWM;
    assign tick     = !pre_on || pdiv_reg == 8'h00;
    assign rise     = s2_reg && !s3_reg;
    assign fall     = !s2_reg && s3_reg;
    assign rtc_tick = run && op == tcp_pkg::OP_RTC && rise && rdiv_reg == 17'(RTC_DIV - 1);
    assign to_evt   = run && tick && zero && (op == tcp_pkg::OP_32 || op == tcp_pkg::OP_16);
    assign cm_evt   = run && op == tcp_pkg::OP_ECNT && sel_edge && dec == match_v;
    assign ce_evt   = run && op == tcp_pkg::OP_ETIME && sel_edge;
    assign rtc_evt  = rtc_tick && cnt_reg == match_reg;
    assign clr      = (we && waddr_reg == tcp_pkg::ICR_OFF && wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0;

    always_comb begin
        unique case (ctl_reg.edge_select_field)
            tcp_pkg::EV_RISE: sel_edge = rise;
            tcp_pkg::EV_FALL: sel_edge = fall;
            tcp_pkg::EV_BOTH: sel_edge = rise || fall;
            default:          sel_edge = 1'b0;
        endcase
    end

    // Capture pin synchroniser and edge history
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= ccp_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Write channel capture
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awready_o   <= 1'b1;
            wready_o    <= 1'b1;
            waddr_reg   <= 12'h000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else if (bvalid_o && bready_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awready_o   <= 1'b1;
            wready_o    <= 1'b1;
        end else begin
            if (awvalid_i && awready_o) begin
                waddr_reg   <= awaddr_i;
                aw_full_reg <= 1'b1;
                awready_o   <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                wdata_reg  <= wdata_i;
                wstrb_reg  <= wstrb_i;
                w_full_reg <= 1'b1;
                wready_o   <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_o <= 1'b0;
            bresp_o  <= tcp_pkg::RESP_OK;
        end else if (we) begin
            bvalid_o <= 1'b1;
            bresp_o  <= mapped(waddr_reg) ? tcp_pkg::RESP_OK : tcp_pkg::RESP_ERR;
        end else if (bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // Read channel
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (araddr_i)
            tcp_pkg::CFG_OFF:   rd_data = {29'h0, cfg_reg};
            tcp_pkg::MODE_OFF:  rd_data = {28'h0, mode_reg};
            tcp_pkg::CTL_OFF:   rd_data = {25'h0, ctl_reg};
            tcp_pkg::IMR_OFF:   rd_data = {28'h0, imr_reg};
            tcp_pkg::RIS_OFF:   rd_data = {28'h0, ris_reg};
            tcp_pkg::MIS_OFF:   rd_data = {28'h0, ris_reg & imr_reg};
            tcp_pkg::ILR_OFF:   rd_data = ilr_v;
            tcp_pkg::MATCH_OFF: rd_data = match_v;
            tcp_pkg::PRE_OFF:   rd_data = {24'h0, pre_reg};
            tcp_pkg::VAL_OFF:   rd_data = w16(h16, op == tcp_pkg::OP_ETIME ? cap_reg : cnt_reg);
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_o <= 1'b1;
            rvalid_o  <= 1'b0;
            rdata_o   <= 32'h0000_0000;
            rresp_o   <= tcp_pkg::RESP_OK;
        end else if (arvalid_i && arready_o) begin
            arready_o <= 1'b0;
            rvalid_o  <= 1'b1;
            rdata_o   <= rd_data;
            rresp_o   <= mapped(araddr_i) ? tcp_pkg::RESP_OK : tcp_pkg::RESP_ERR;
        end else if (rvalid_o && rready_i) begin
            arready_o <= 1'b1;
            rvalid_o  <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg   <= tcp_pkg::CFG_32;
            mode_reg  <= '0;
            imr_reg   <= 4'h0;
            ilr_reg   <= tcp_pkg::ILR_RST;
            match_reg <= tcp_pkg::MATCH_RST;
            pre_reg   <= 8'h00;
        end else if (we) begin
            unique case (waddr_reg)
                tcp_pkg::CFG_OFF:   cfg_reg   <= 3'(merge({29'h0, cfg_reg}, wdata_reg, wstrb_reg));
                tcp_pkg::MODE_OFF:  mode_reg  <= tcp_pkg::tcp_mode_s'(4'(merge({28'h0, mode_reg}, wdata_reg, wstrb_reg)));
                tcp_pkg::IMR_OFF:   imr_reg   <= 4'(merge({28'h0, imr_reg}, wdata_reg, wstrb_reg));
                tcp_pkg::ILR_OFF:   ilr_reg   <= merge(ilr_reg, wdata_reg, wstrb_reg);
                tcp_pkg::MATCH_OFF: match_reg <= merge(match_reg, wdata_reg, wstrb_reg);
                tcp_pkg::PRE_OFF:   pre_reg   <= 8'(merge({24'h0, pre_reg}, wdata_reg, wstrb_reg));
                default:            ;
            endcase
        end
    end

    // Pending interval load update
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ilr_wr_reg <= 1'b0;
        end else begin
            ilr_wr_reg <= we && waddr_reg == tcp_pkg::ILR_OFF;
        end
    end

    // Control register; software write beats hardware stop
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_reg <= '0;
        end else if (we && waddr_reg == tcp_pkg::CTL_OFF) begin
            ctl_reg <= tcp_pkg::tcp_ctl_s'(7'(merge({25'h0, ctl_reg}, wdata_reg, wstrb_reg)));
        end else if (to_evt && mode_reg.timer_mode_field == tcp_pkg::MR_ONESHOT) begin
            ctl_reg.timer_run_bit <= 1'b0;
        end else if (cm_evt) begin
            ctl_reg.timer_run_bit <= 1'b0;
        end
    end

    // Status flags; a new event wins over a clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ris_reg <= 4'h0;
        end else begin
            ris_reg <= (ris_reg & ~clr)
                     | {rtc_evt, ce_evt, cm_evt, to_evt};
        end
    end

    // Prescale divider
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pdiv_reg <= 8'h00;
        end else if (!run || !pre_on || pdiv_reg == 8'h00) begin
            pdiv_reg <= pre_reg;
        end else begin
            pdiv_reg <= pdiv_reg - 8'h01;
        end
    end

    // RTC divider on the external 32.768 kHz input
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdiv_reg <= 17'h0_0000;
        end else if (!run || op != tcp_pkg::OP_RTC || rtc_tick) begin
            rdiv_reg <= 17'h0_0000;
        end else if (rise) begin
            rdiv_reg <= rdiv_reg + 17'h0_0001;
        end
    end

    // Main counter
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= tcp_pkg::CNT_RST;
        end else if (we && waddr_reg == tcp_pkg::CFG_OFF && wdata_reg[2:0] == tcp_pkg::CFG_RTC) begin
            cnt_reg <= tcp_pkg::RTC_START;
        end else if (!run) begin
            if (op != tcp_pkg::OP_RTC) begin
                cnt_reg <= ilr_v;
            end
        end else if (ilr_wr_reg && op != tcp_pkg::OP_ECNT && op != tcp_pkg::OP_RTC) begin
            cnt_reg <= ilr_v;
        end else begin
            unique case (op)
                tcp_pkg::OP_32, tcp_pkg::OP_16, tcp_pkg::OP_PWM, tcp_pkg::OP_ETIME: begin
                    if (tick) begin
                        cnt_reg <= zero ? ilr_v : dec;
                    end
                end
                tcp_pkg::OP_RTC: begin
                    if (rtc_tick) begin
                        cnt_reg <= rtc_evt ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
                    end
                end
                tcp_pkg::OP_ECNT: begin
                    if (sel_edge) begin
                        cnt_reg <= cm_evt ? ilr_v : dec;
                    end
                end
                default: ;
            endcase
        end
    end

    // Capture register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_reg <= tcp_pkg::CNT_RST;
        end else if (ce_evt) begin
            cap_reg <= cnt_reg;
        end
    end

    // PWM level and pin drive
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_reg  <= 1'b0;
            ccp_o    <= 1'b0;
            ccp_oe_o <= 1'b0;
        end else begin
            if (!run || op != tcp_pkg::OP_PWM) begin
                lvl_reg <= 1'b0;
            end else if (cnt_reg == ilr_v) begin
                lvl_reg <= 1'b1;
            end else if (cnt_reg == match_v) begin
                lvl_reg <= 1'b0;
            end
            ccp_o    <= lvl_reg ^ ctl_reg.output_invert_bit;
            ccp_oe_o <= run && op == tcp_pkg::OP_PWM;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_etime_step;
        run && op == tcp_pkg::OP_ETIME && !ilr_wr_reg && !zero && !we;
    endsequence

    sequence s_pwm_start;
        run && op == tcp_pkg::OP_PWM && cnt_reg == ilr_v && cnt_reg != match_v ##1 run;
    endsequence

    sequence s_pwm_match;
        run && op == tcp_pkg::OP_PWM && cnt_reg == match_v && cnt_reg != ilr_v ##1 run;
    endsequence

    a_no_prescale: assert property (s_etime_step |=> cnt_reg == $past(dec))
        else $error("edge-time counter skipped a cycle");
    a_etime_reload: assert property (run && op == tcp_pkg::OP_ETIME && zero && !ilr_wr_reg && !we
                                     |=> cnt_reg == $past(ilr_v))
        else $error("edge-time counter did not reload");
    a_capture_copy: assert property (ce_evt |=> cap_reg == $past(cnt_reg) && ris_reg[tcp_pkg::IRQ_CE])
        else $error("capture not taken");
    a_capture_hold: assert property (!ce_evt |=> $stable(cap_reg))
        else $error("capture changed without edge");
    a_ilr_write: assert property (we && waddr_reg == tcp_pkg::ILR_OFF && run
                                  && (op == tcp_pkg::OP_ETIME || op == tcp_pkg::OP_PWM)
                                  ##1 run && !we |=> cnt_reg == $past(ilr_v))
        else $error("interval load not applied next cycle");
    a_pwm_quiet: assert property (op == tcp_pkg::OP_PWM && clr == 4'h0 |=> $stable(ris_reg))
        else $error("flag set in pwm mode");
    a_pwm_rise: assert property (s_pwm_start |=> ccp_o == !$past(ctl_reg.output_invert_bit))
        else $error("pwm not active at start");
    a_pwm_fall: assert property (s_pwm_match |=> ccp_o == $past(ctl_reg.output_invert_bit))
        else $error("pwm not inactive at match");
    a_oneshot_stop: assert property (to_evt && mode_reg.timer_mode_field == tcp_pkg::MR_ONESHOT && !we
                                     |=> !run)
        else $error("one-shot kept running");
    a_ecnt_done: assert property (cm_evt && !we |=> !run && cnt_reg == $past(ilr_v))
        else $error("edge count did not stop");
    a_icr_clear: assert property (clr[tcp_pkg::IRQ_TO] && !to_evt |=> !ris_reg[tcp_pkg::IRQ_TO])
        else $error("timeout flag not cleared");
    a_rtc_wrap: assert property (rtc_evt && !we |=> cnt_reg == 32'h0000_0000)
        else $error("rtc did not wrap");

endmodule

//--- bench/tcp_pin_model.sv
// Partner on the capture pin: an edge source and a load that counts PWM high cycles.
// Assumes the bench calls toggle_pin and clears high_cnt.
`timescale 1ns/1ps
module tcp_pin_model (
    input  wire logic clock_i,
    input  wire logic out_i,
    input  wire logic oe_i,
    output logic      pin_o
);
    logic ext_lvl = 1'b0;
    int   high_cnt = 0;
    // Released pin shows the source level
    assign pin_o = oe_i ? out_i : ext_lvl;
    always @(posedge clock_i) begin
        if (oe_i && out_i) high_cnt++;
    end
    // Edges spaced well beyond the synchroniser delay
    task automatic toggle_pin(input int n);
        repeat (n) begin
            repeat (6) @(posedge clock_i);
            ext_lvl <= ~ext_lvl;
        end
        // Let the last edge pass the synchroniser
        repeat (6) @(posedge clock_i);
    endtask
endmodule

//--- bench/tb_timer_capture_pwm_modes.sv
// Self-checking bench for the timer: registers, edge time, edge count, PWM, one-shot.
// Assumes tcp_timer, tcp_pkg and tcp_pin_model are compiled first.
`timescale 1ns/1ps
module tb_timer_capture_pwm_modes;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} tcp_row_s;
    logic        clock_i, rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, ccp_i;
    logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, ccp_o, ccp_oe_o;
    logic [11:0] awaddr_i, araddr_i;
    logic [31:0] wdata_i, rdata_o, v1, v2;
    logic [3:0]  wstrb_i;
    logic [1:0]  bresp_o, rresp_o, rsp;
    int          bad_count = 0, checked = 0, cyc = 0;
    tcp_row_s rows [13] = '{
        '{1'b0, tcp_pkg::CFG_OFF, 32'h0, 32'h0}, '{1'b0, tcp_pkg::MODE_OFF, 32'h0, 32'h0},
        '{1'b0, tcp_pkg::CTL_OFF, 32'h0, 32'h0}, '{1'b0, tcp_pkg::IMR_OFF, 32'h0, 32'h0},
        '{1'b0, tcp_pkg::RIS_OFF, 32'h0, 32'h0}, '{1'b0, tcp_pkg::ILR_OFF, 32'h0, 32'hFFFFFFFF},
        '{1'b0, tcp_pkg::MATCH_OFF, 32'h0, 32'hFFFFFFFF}, '{1'b0, tcp_pkg::PRE_OFF, 32'h0, 32'h0},
        '{1'b1, tcp_pkg::PRE_OFF, 32'h1FF, 32'hFF}, '{1'b1, tcp_pkg::ICR_OFF, 32'hF, 32'h0},
        '{1'b1, tcp_pkg::CFG_OFF, 32'h4, 32'h4}, '{1'b1, tcp_pkg::ILR_OFF, 32'h1FFFF, 32'hFFFF},
        '{1'b1, tcp_pkg::IMR_OFF, 32'h4, 32'h4}};

    tcp_timer #(.RTC_DIV(4)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .awaddr_i(awaddr_i),
        .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
        .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
        .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .ccp_i(ccp_i), .ccp_o(ccp_o), .ccp_oe_o(ccp_oe_o));
    tcp_pin_model pm_u (.clock_i(clock_i), .out_i(ccp_o), .oe_i(ccp_oe_o), .pin_o(ccp_i));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    task automatic end_sim;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        awaddr_i <= a;
        wdata_i <= d;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awvalid_i && awready_o) awvalid_i <= 1'b0;
            if (wvalid_i && wready_o) wvalid_i <= 1'b0;
        end while (!(bvalid_o && bready_i));
        bready_i <= 1'b0;
        chk({30'h0, bresp_o}, {30'h0, tcp_pkg::RESP_OK});
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arvalid_i && arready_o) arvalid_i <= 1'b0;
        end while (!(rvalid_o && rready_i));
        rready_i <= 1'b0;
        d = rdata_o;
        r = rresp_o;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, tcp_pkg::RESP_OK});
    endtask
    task automatic pwm_high(input logic [31:0] e);
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        pm_u.high_cnt = 0;
        repeat (40) @(negedge clock_i);
        chk(pm_u.high_cnt, e);
    endtask

    initial begin
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, awaddr_i, araddr_i, wdata_i} = '0;
        wstrb_i = 4'hF;
        rst_n_i = 1'b0;
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].e);
        end
        // Edge time with the prescaler loaded: it must stay out of the count
        wr(tcp_pkg::MODE_OFF, 32'h7);
        wr(tcp_pkg::CTL_OFF, 32'h1);
        pm_u.toggle_pin(2);
        rc(tcp_pkg::MIS_OFF, 32'h4);
        rd(tcp_pkg::VAL_OFF, v1, rsp);
        repeat (20) @(posedge clock_i);
        rc(tcp_pkg::VAL_OFF, v1);
        pm_u.toggle_pin(2);
        rd(tcp_pkg::VAL_OFF, v2, rsp);
        chk({31'h0, v2 < v1 && v1 - v2 > 8}, 32'h1);
        wr(tcp_pkg::ICR_OFF, 32'h0);
        rc(tcp_pkg::RIS_OFF, 32'h4);
        wr(tcp_pkg::ICR_OFF, 32'h4);
        rc(tcp_pkg::RIS_OFF, 32'h0);
        // Edge count on both edges: four edges from 10 down to 6
        wr(tcp_pkg::CTL_OFF, 32'h0);
        wr(tcp_pkg::MODE_OFF, 32'h3);
        wr(tcp_pkg::ILR_OFF, 32'hA);
        wr(tcp_pkg::MATCH_OFF, 32'h6);
        wr(tcp_pkg::CTL_OFF, 32'hD);
        pm_u.toggle_pin(4);
        rc(tcp_pkg::RIS_OFF, 32'h2);
        rc(tcp_pkg::CTL_OFF, 32'hC);
        rc(tcp_pkg::VAL_OFF, 32'hA);
        wr(tcp_pkg::ICR_OFF, 32'hF);
        // PWM: period 10, high from count 9 down to 3
        wr(tcp_pkg::CTL_OFF, 32'h0);
        wr(tcp_pkg::MODE_OFF, 32'hA);
        wr(tcp_pkg::PRE_OFF, 32'h0);
        wr(tcp_pkg::ILR_OFF, 32'h9);
        wr(tcp_pkg::MATCH_OFF, 32'h2);
        wr(tcp_pkg::CTL_OFF, 32'h1);
        pwm_high(32'h1C);
        wr(tcp_pkg::CTL_OFF, 32'h40);
        wr(tcp_pkg::CTL_OFF, 32'h41);
        pwm_high(32'h0C);
        wr(tcp_pkg::ILR_OFF, 32'h4);
        pwm_high(32'h18);
        rc(tcp_pkg::RIS_OFF, 32'h0);
        // Unmapped read answers with an error and zero data
        rd(12'h100, v1, rsp);
        chk(v1, 32'h0);
        chk({30'h0, rsp}, {30'h0, tcp_pkg::RESP_ERR});
        // One-shot stops itself after time-out
        wr(tcp_pkg::CTL_OFF, 32'h0);
        @(negedge clock_i);
        chk({31'h0, ccp_oe_o}, 32'h0);
        wr(tcp_pkg::MODE_OFF, 32'h1);
        wr(tcp_pkg::ILR_OFF, 32'h5);
        wr(tcp_pkg::CTL_OFF, 32'h1);
        repeat (30) @(posedge clock_i);
        rc(tcp_pkg::CTL_OFF, 32'h0);
        rc(tcp_pkg::RIS_OFF, 32'h1);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rc(tcp_pkg::RIS_OFF, 32'h0);
        // RTC: two ticks of four input rises, wrap on match 2
        wr(tcp_pkg::CFG_OFF, 32'h1);
        wr(tcp_pkg::MATCH_OFF, 32'h2);
        wr(tcp_pkg::CTL_OFF, 32'h1);
        pm_u.toggle_pin(16);
        rc(tcp_pkg::RIS_OFF, 32'h8);
        rc(tcp_pkg::VAL_OFF, 32'h0);
        // 32-bit periodic keeps running after time-out
        wr(tcp_pkg::CTL_OFF, 32'h0);
        wr(tcp_pkg::CFG_OFF, 32'h0);
        wr(tcp_pkg::MODE_OFF, 32'h2);
        wr(tcp_pkg::ILR_OFF, 32'h3);
        wr(tcp_pkg::CTL_OFF, 32'h1);
        repeat (20) @(posedge clock_i);
        rc(tcp_pkg::CTL_OFF, 32'h1);
        rc(tcp_pkg::RIS_OFF, 32'h9);
        end_sim();
    end
endmodule
